// file: fsicr_regs.v
// fail-safe init configuration register bank with reset pulse and low timer
`timescale 1ns/100ps
`include "fsicr_consts.vh"

module fsicr_regs #(
	parameter [`FSICR_CNT_W-1:0] PULSE_LONG_CYC  = `FSICR_PULSE_LONG_CYC,
	parameter [`FSICR_CNT_W-1:0] PULSE_SHORT_CYC = `FSICR_PULSE_SHORT_CYC,
	parameter [`FSICR_CNT_W-1:0] LOW_TIMEOUT_CYC = `FSICR_LOW_TIMEOUT_CYC
) (
	input  wire                      clk_sys_in,
	input  wire                      srst_in,
	input  wire                      wr_en_in,
	input  wire                      rd_en_in,
	input  wire [`FSICR_ADDR_W-1:0]  addr_in,
	input  wire [`FSICR_DATA_W-1:0]  wr_data_in,
	output reg  [`FSICR_DATA_W-1:0]  rd_data_out,
	input  wire [3:0]                fault_counter_value_in,
	input  wire                      reset_request_in,
	input  wire                      reset_pin_sense_n_in,
	output reg                       reset_output_pin_n_out,
	output reg                       long_low_timeout_out,
	output reg  [1:0]                core_over_reaction_out,
	output reg  [1:0]                core_under_reaction_out,
	output reg  [1:0]                io_supply_over_reaction_out,
	output reg  [1:0]                io_supply_under_reaction_out,
	output reg  [1:0]                aux_monitor_over_reaction_out,
	output reg  [1:0]                aux_monitor_under_reaction_out,
	output reg  [1:0]                fault_counter_limit_out,
	output reg                       reset_pulse_length_sel_out,
	output reg                       long_low_timer_disable_out,
	output reg  [4:0]                scaling_offset_code_out,
	output reg  [4:0]                scaling_offset_applied_out
);

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	// strobe qualified by one register index
	function reg_hit;
		input                     strobe;
		input [`FSICR_ADDR_W-1:0] addr;
		input [`FSICR_ADDR_W-1:0] idx;
		begin
			reg_hit = strobe && (addr == idx);
		end
	endfunction

	// two-bit selector field starting at a given data bit
	function [1:0] pair_at;
		input [`FSICR_DATA_W-1:0] word;
		input integer             lo;
		begin
			pair_at = word[lo +: 2];
		end
	endfunction

	// codes above 1 0000 have no meaning, the deepest step is the safe reading
	function [4:0] clamp_offset;
		input [4:0] code;
		begin
			if (code > `FSICR_OFFS_MAX) begin
				clamp_offset = `FSICR_OFFS_MAX;
			end else begin
				clamp_offset = code;
			end
		end
	endfunction

	// -----------------------------------------------------------------
	// register write path
	// -----------------------------------------------------------------
	wire wr_react1 = reg_hit(wr_en_in, addr_in, `FSICR_IDX_REACT1);
	wire wr_react2 = reg_hit(wr_en_in, addr_in, `FSICR_IDX_REACT2);
	wire wr_fssm   = reg_hit(wr_en_in, addr_in, `FSICR_IDX_FSSM);
	wire wr_svs    = reg_hit(wr_en_in, addr_in, `FSICR_IDX_SVS);

	// only named fields are stored, other bits are simply dropped
	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			core_over_reaction_out         <= `FSICR_RST_OV;
			core_under_reaction_out        <= `FSICR_RST_UV;
			io_supply_over_reaction_out    <= `FSICR_RST_OV;
			io_supply_under_reaction_out   <= `FSICR_RST_UV;
			aux_monitor_over_reaction_out  <= `FSICR_RST_OV;
			aux_monitor_under_reaction_out <= `FSICR_RST_UV;
			fault_counter_limit_out        <= `FSICR_RST_LIMIT;
			reset_pulse_length_sel_out     <= 1'b0;
			long_low_timer_disable_out     <= 1'b0;
			scaling_offset_code_out        <= `FSICR_RST_OFFS;
		end else begin
			if (wr_react1) begin
				core_over_reaction_out       <= pair_at(wr_data_in, `FSICR_CORE_OV_LO);
				core_under_reaction_out      <= pair_at(wr_data_in, `FSICR_CORE_UV_LO);
				io_supply_over_reaction_out  <= pair_at(wr_data_in, `FSICR_LOW_OV_LO);
				io_supply_under_reaction_out <= pair_at(wr_data_in, `FSICR_LOW_UV_LO);
			end
			if (wr_react2) begin
				aux_monitor_over_reaction_out  <= pair_at(wr_data_in, `FSICR_LOW_OV_LO);
				aux_monitor_under_reaction_out <= pair_at(wr_data_in, `FSICR_LOW_UV_LO);
			end
			if (wr_fssm) begin
				fault_counter_limit_out    <= pair_at(wr_data_in, `FSICR_LIMIT_LO);
				reset_pulse_length_sel_out <= wr_data_in[`FSICR_PULSE_BIT];
				long_low_timer_disable_out <= wr_data_in[`FSICR_DIS8_BIT];
			end
			if (wr_svs) begin
				scaling_offset_code_out <= wr_data_in[`FSICR_OFFS_HI:`FSICR_OFFS_LO];
			end
		end
	end

	// -----------------------------------------------------------------
	// offset applied to the regulator, in 6.25 mV steps
	// -----------------------------------------------------------------
	// raw code stays readable, only the applied value is limited
	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			scaling_offset_applied_out <= `FSICR_RST_OFFS;
		end else begin
			scaling_offset_applied_out <= clamp_offset(scaling_offset_code_out);
		end
	end

	// -----------------------------------------------------------------
	// read path
	// -----------------------------------------------------------------
	reg [`FSICR_DATA_W-1:0] nxt_rd_data;

	// fault count comes straight from the input, so a read is never stale
	always @* begin
		nxt_rd_data = {`FSICR_DATA_W{1'b0}};
		case (addr_in)
			`FSICR_IDX_REACT1: begin
				nxt_rd_data[`FSICR_CORE_OV_HI:`FSICR_CORE_OV_LO] = core_over_reaction_out;
				nxt_rd_data[`FSICR_CORE_UV_HI:`FSICR_CORE_UV_LO] = core_under_reaction_out;
				nxt_rd_data[`FSICR_LOW_OV_HI:`FSICR_LOW_OV_LO]   = io_supply_over_reaction_out;
				nxt_rd_data[`FSICR_LOW_UV_HI:`FSICR_LOW_UV_LO]   = io_supply_under_reaction_out;
			end
			`FSICR_IDX_REACT2: begin
				nxt_rd_data[`FSICR_LOW_OV_HI:`FSICR_LOW_OV_LO] = aux_monitor_over_reaction_out;
				nxt_rd_data[`FSICR_LOW_UV_HI:`FSICR_LOW_UV_LO] = aux_monitor_under_reaction_out;
			end
			`FSICR_IDX_FSSM: begin
				nxt_rd_data[`FSICR_LIMIT_HI:`FSICR_LIMIT_LO] = fault_counter_limit_out;
				nxt_rd_data[`FSICR_PULSE_BIT]               = reset_pulse_length_sel_out;
				nxt_rd_data[`FSICR_DIS8_BIT]                = long_low_timer_disable_out;
				nxt_rd_data[3:0]                            = fault_counter_value_in;
			end
			`FSICR_IDX_SVS: begin
				nxt_rd_data[`FSICR_OFFS_HI:`FSICR_OFFS_LO] = scaling_offset_code_out;
			end
			default: begin
				nxt_rd_data = {`FSICR_DATA_W{1'b0}};
			end
		endcase
	end

	// data held between reads so the frame engine can shift it out
	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			rd_data_out <= {`FSICR_DATA_W{1'b0}};
		end else if (rd_en_in) begin
			rd_data_out <= nxt_rd_data;
		end
	end

	// -----------------------------------------------------------------
	// reset output pulse
	// -----------------------------------------------------------------
	reg  [`FSICR_CNT_W-1:0] pulse_cnt_ff;
	wire [`FSICR_CNT_W-1:0] pulse_len = reset_pulse_length_sel_out ?
		PULSE_SHORT_CYC : PULSE_LONG_CYC;

	// a request during a pulse restarts it, so the pin never glitches high
	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			pulse_cnt_ff           <= {`FSICR_CNT_W{1'b0}};
			reset_output_pin_n_out <= 1'b1;
		end else if (reset_request_in) begin
			pulse_cnt_ff           <= pulse_len - 1'b1;
			reset_output_pin_n_out <= 1'b0;
		end else if (pulse_cnt_ff != {`FSICR_CNT_W{1'b0}}) begin
			pulse_cnt_ff           <= pulse_cnt_ff - 1'b1;
			reset_output_pin_n_out <= 1'b0;
		end else begin
			reset_output_pin_n_out <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// long reset-low timer on the sensed pin
	// -----------------------------------------------------------------
	reg                     sense_meta_ff;
	reg                     sense_sync_ff;
	reg [`FSICR_CNT_W-1:0]  low_cnt_ff;

	// two flops, the sensed line is not on this clock
	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			sense_meta_ff <= 1'b1;
			sense_sync_ff <= 1'b1;
		end else begin
			sense_meta_ff <= reset_pin_sense_n_in;
			sense_sync_ff <= sense_meta_ff;
		end
	end

	// the pin may be held low from outside too, hence the sensed level
	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			low_cnt_ff           <= {`FSICR_CNT_W{1'b0}};
			long_low_timeout_out <= 1'b0;
		end else if (sense_sync_ff || long_low_timer_disable_out) begin
			low_cnt_ff           <= {`FSICR_CNT_W{1'b0}};
			long_low_timeout_out <= 1'b0;
		end else if (low_cnt_ff == LOW_TIMEOUT_CYC - 1'b1) begin
			long_low_timeout_out <= 1'b1;
		end else begin
			low_cnt_ff           <= low_cnt_ff + 1'b1;
			long_low_timeout_out <= 1'b0;
		end
	end

endmodule // fsicr_regs

// file: fsicr_consts.vh
// constants for the fail-safe init configuration register bank
`ifndef FSICR_CONSTS_VH
`define FSICR_CONSTS_VH

// -----------------------------------------------------------------
// register indices and data layout (data bit 15 is frame bit 23)
// -----------------------------------------------------------------
`define FSICR_ADDR_W        2
`define FSICR_IDX_REACT1    2'h0
`define FSICR_IDX_REACT2    2'h1
`define FSICR_IDX_FSSM      2'h2
`define FSICR_IDX_SVS       2'h3
`define FSICR_DATA_W        16

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define FSICR_CORE_OV_HI    15
`define FSICR_CORE_OV_LO    14
`define FSICR_CORE_UV_HI    13
`define FSICR_CORE_UV_LO    12
`define FSICR_LOW_OV_HI     3
`define FSICR_LOW_OV_LO     2
`define FSICR_LOW_UV_HI     1
`define FSICR_LOW_UV_LO     0
`define FSICR_LIMIT_HI      15
`define FSICR_LIMIT_LO      14
`define FSICR_PULSE_BIT     9
`define FSICR_DIS8_BIT      4
`define FSICR_OFFS_HI       15
`define FSICR_OFFS_LO       11

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define FSICR_RST_OV        2'h3
`define FSICR_RST_UV        2'h1
`define FSICR_RST_LIMIT     2'h1
`define FSICR_RST_OFFS      5'h00
`define FSICR_OFFS_MAX      5'h10

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define FSICR_CLK_HZ        20000000
`define FSICR_PULSE_LONG_US 10000
`define FSICR_PULSE_SHORT_US 1000
`define FSICR_LOW_TIMEOUT_S 8
// 10 ms, 1.0 ms and 8 s at the 20 MHz clock, sized to the counter width
`define FSICR_PULSE_LONG_CYC  28'h0030D40
`define FSICR_PULSE_SHORT_CYC 28'h0004E20
`define FSICR_LOW_TIMEOUT_CYC 28'h9896800
`define FSICR_CNT_W         28

`endif

// file: fsicr_line_model.sv
// model of the board reset line and an outside part that can hold it low
`timescale 1ns/100ps
// -----
// reset line
// -----
module fsicr_line_model (
	input  wire drive_n_in,
	input  wire hold_low_in,
	output wire line_n_out
);
	// pulled up, so the line is low only while one party pulls it down
	assign line_n_out = drive_n_in & ~hold_low_in;
endmodule // fsicr_line_model

// file: fsicr_regs_props.sv
// assertions for the fail-safe init register bank
`timescale 1ns/100ps
// -----
// checker
// -----
module fsicr_props #(
	parameter [27:0] PULSE_LONG_CYC  = 20,
	parameter [27:0] PULSE_SHORT_CYC = 4,
	parameter [27:0] LOW_TIMEOUT_CYC = 30
) (
	input wire        clk_sys_in,
	input wire        srst_in,
	input wire        wr_en_in,
	input wire        rd_en_in,
	input wire [1:0]  addr_in,
	input wire [15:0] wr_data_in,
	input wire [15:0] rd_data_out,
	input wire [3:0]  fault_counter_value_in,
	input wire        reset_request_in,
	input wire        reset_pin_sense_n_in,
	input wire        reset_output_pin_n_out,
	input wire        long_low_timeout_out,
	input wire [1:0]  core_over_reaction_out,
	input wire [1:0]  core_under_reaction_out,
	input wire [1:0]  io_supply_over_reaction_out,
	input wire [1:0]  io_supply_under_reaction_out,
	input wire [1:0]  aux_monitor_over_reaction_out,
	input wire [1:0]  aux_monitor_under_reaction_out,
	input wire [1:0]  fault_counter_limit_out,
	input wire        reset_pulse_length_sel_out,
	input wire        long_low_timer_disable_out,
	input wire [4:0]  scaling_offset_code_out,
	input wire [4:0]  scaling_offset_applied_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	// consecutive cycles with the sensed line low, saturating
	reg [27:0] low_run_ff;
	always @(posedge clk_sys_in) begin
		if (srst_in || reset_pin_sense_n_in) begin
			low_run_ff <= 28'h0000000;
		end else if (low_run_ff != 28'hFFFFFFF) begin
			low_run_ff <= low_run_ff + 28'h0000001;
		end
	end
	rd_state_a: assert property (
		rd_en_in && addr_in == 2'h2 |=> rd_data_out == $past({fault_counter_limit_out, 4'h0,
		reset_pulse_length_sel_out, 4'h0, long_low_timer_disable_out, fault_counter_value_in}))
		else $error("state word read wrong");
	rd_scale_a: assert property (
		rd_en_in && addr_in == 2'h3 |=> rd_data_out == {$past(scaling_offset_code_out), 11'h000})
		else $error("offset word read wrong");
	rd_react_a: assert property (
		rd_en_in && addr_in == 2'h0 |=> rd_data_out == $past({core_over_reaction_out,
		core_under_reaction_out, 8'h00, io_supply_over_reaction_out, io_supply_under_reaction_out}))
		else $error("reaction word read wrong");
	rd_aux_a: assert property (
		rd_en_in && addr_in == 2'h1 |=> rd_data_out == $past({12'h000,
		aux_monitor_over_reaction_out, aux_monitor_under_reaction_out}))
		else $error("aux reaction word read wrong");
	wr_state_a: assert property (
		wr_en_in && addr_in == 2'h2 |=> reset_pulse_length_sel_out == $past(wr_data_in[9])
		&& long_low_timer_disable_out == $past(wr_data_in[4])) else $error("state write lost");
	short_low_a: assert property (
		reset_request_in && reset_pulse_length_sel_out |=> !reset_output_pin_n_out [*4])
		else $error("short pulse cut early");
	short_end_a: assert property (
		reset_request_in && reset_pulse_length_sel_out ##1 !reset_request_in [*4]
		|=> reset_output_pin_n_out) else $error("short pulse too long");
	long_end_a: assert property (
		reset_request_in && !reset_pulse_length_sel_out ##1 !reset_request_in [*8]
		##1 !reset_request_in [*8] ##1 !reset_request_in [*4] |=> reset_output_pin_n_out)
		else $error("long pulse length wrong");
	timer_off_a: assert property (
		long_low_timer_disable_out |=> !long_low_timeout_out) else $error("timer not stopped");
	timer_run_a: assert property (
		$rose(long_low_timeout_out) |-> !$past(long_low_timer_disable_out)
		&& low_run_ff >= LOW_TIMEOUT_CYC) else $error("timeout without long low");
	applied_a: assert property (
		scaling_offset_applied_out == ($past(scaling_offset_code_out) > 5'h10 ? 5'h10
		: $past(scaling_offset_code_out))) else $error("applied offset wrong");
	cover property (rd_en_in && addr_in == 2'h2);
	cover property (reset_request_in && reset_pulse_length_sel_out);
	cover property ($rose(long_low_timeout_out));
endmodule // fsicr_props

bind fsicr_regs fsicr_props #(.PULSE_LONG_CYC(PULSE_LONG_CYC), .PULSE_SHORT_CYC(PULSE_SHORT_CYC),
	.LOW_TIMEOUT_CYC(LOW_TIMEOUT_CYC)) fsicr_props_inst (
	.clk_sys_in                     (clk_sys_in),
	.srst_in                        (srst_in),
	.wr_en_in                       (wr_en_in),
	.rd_en_in                       (rd_en_in),
	.addr_in                        (addr_in),
	.wr_data_in                     (wr_data_in),
	.rd_data_out                    (rd_data_out),
	.fault_counter_value_in         (fault_counter_value_in),
	.reset_request_in               (reset_request_in),
	.reset_pin_sense_n_in           (reset_pin_sense_n_in),
	.reset_output_pin_n_out         (reset_output_pin_n_out),
	.long_low_timeout_out           (long_low_timeout_out),
	.core_over_reaction_out         (core_over_reaction_out),
	.core_under_reaction_out        (core_under_reaction_out),
	.io_supply_over_reaction_out    (io_supply_over_reaction_out),
	.io_supply_under_reaction_out   (io_supply_under_reaction_out),
	.aux_monitor_over_reaction_out  (aux_monitor_over_reaction_out),
	.aux_monitor_under_reaction_out (aux_monitor_under_reaction_out),
	.fault_counter_limit_out        (fault_counter_limit_out),
	.reset_pulse_length_sel_out     (reset_pulse_length_sel_out),
	.long_low_timer_disable_out     (long_low_timer_disable_out),
	.scaling_offset_code_out        (scaling_offset_code_out),
	.scaling_offset_applied_out     (scaling_offset_applied_out)
);

// file: fsicr_regs_tb.sv
// testbench for the fail-safe init register bank
`timescale 1ns/100ps
`include "fsicr_consts.vh"
// -----
// bench
// -----
module fsicr_regs_tb;
	reg         clk = 1'b0;
	reg         srst = 1'b1;
	reg         wr_en = 1'b0;
	reg         rd_en = 1'b0;
	reg  [1:0]  addr = 2'h0;
	reg  [15:0] wdata = 16'h0000;
	reg  [3:0]  fault = 4'h5;
	reg         req = 1'b0;
	reg         hold_low = 1'b0;
	wire        sense_n;
	wire        pin_n;
	wire        tmo;
	wire [15:0] rdata;
	wire [4:0]  applied;
	integer     bad_count = 0;
	integer     num_checks = 0;
	integer     cyc = 0;
	integer     n;
	fsicr_regs #(.PULSE_LONG_CYC(28'd20), .PULSE_SHORT_CYC(28'd4), .LOW_TIMEOUT_CYC(28'd30))
	fsicr_regs_inst (.clk_sys_in(clk), .srst_in(srst), .wr_en_in(wr_en), .rd_en_in(rd_en),
		.addr_in(addr), .wr_data_in(wdata), .rd_data_out(rdata), .fault_counter_value_in(fault),
		.reset_request_in(req), .reset_pin_sense_n_in(sense_n), .reset_output_pin_n_out(pin_n),
		.long_low_timeout_out(tmo), .core_over_reaction_out(), .core_under_reaction_out(),
		.io_supply_over_reaction_out(), .io_supply_under_reaction_out(),
		.aux_monitor_over_reaction_out(), .aux_monitor_under_reaction_out(),
		.fault_counter_limit_out(), .reset_pulse_length_sel_out(), .long_low_timer_disable_out(),
		.scaling_offset_code_out(), .scaling_offset_applied_out(applied));
	fsicr_line_model fsicr_line_model_inst (.drive_n_in(pin_n), .hold_low_in(hold_low),
		.line_n_out(sense_n));
	initial forever #25 clk = ~clk;
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("mismatch %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [1:0] a, input [15:0] d);
		begin
			@(posedge clk) wr_en <= 1'b1;
			addr <= a;
			wdata <= d;
			@(posedge clk) wr_en <= 1'b0;
		end
	endtask
	task rd(input [1:0] a, input [15:0] exp);
		begin
			@(posedge clk) rd_en <= 1'b1;
			addr <= a;
			@(posedge clk) rd_en <= 1'b0;
			#1 chk(rdata, exp);
		end
	endtask
	// counts low cycles of the reset drive after one request
	task pulse(input [15:0] exp);
		begin
			@(posedge clk) req <= 1'b1;
			@(posedge clk) req <= 1'b0;
			#1 n = 0;
			while (pin_n === 1'b0 && n < 99) begin
				@(posedge clk) #1 n = n + 1;
			end
			chk(n[15:0], exp);
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", num_checks, bad_count);
			if (bad_count == 0 && num_checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// hang guard, far above the roughly 140 cycles the sequence needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count = bad_count + 1;
			stop_test;
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(2'h0, 16'hD00D);
		rd(2'h1, 16'h000D);
		rd(2'h2, 16'h4005);
		rd(2'h3, 16'h0000);
		wr(2'h0, 16'hFFFF);
		wr(2'h1, 16'hFFFF);
		wr(2'h2, 16'hFFFF);
		wr(2'h3, 16'h8000);
		rd(2'h0, 16'hF00F);
		rd(2'h1, 16'h000F);
		rd(2'h3, 16'h8000);
		chk({11'h000, applied}, 16'h0010);
		wr(2'h3, 16'hFFFF);
		rd(2'h3, 16'hF800);
		chk({11'h000, applied}, 16'h0010);
		for (n = 0; n < 13; n = n + 1) begin
			@(posedge clk) fault <= n[3:0];
			rd(2'h2, 16'hC210 | n[15:0]);
		end
		pulse(16'd4);
		wr(2'h2, 16'h0000);
		pulse(16'd20);
		@(posedge clk) hold_low <= 1'b1;
		n = 0;
		while (tmo !== 1'b1 && n < 99) begin
			@(posedge clk) #1 n = n + 1;
		end
		chk({15'h0000, tmo}, 16'h0001);
		chk({15'h0000, n >= 30}, 16'h0001);
		chk({15'h0000, n <= 34}, 16'h0001);
		wr(2'h2, 16'h0010);
		@(posedge clk) #1 chk({15'h0000, tmo}, 16'h0000);
		@(posedge clk) hold_low <= 1'b0;
		// reset in mid-run: fields back to reset values, count stays live
		@(posedge clk) srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(2'h2, 16'h400C);
		stop_test;
	end
endmodule // fsicr_regs_tb
